// file: rtl/dbc_regs.sv
// Control register bank and field decode for the two-channel buck regulator
`timescale 1ns/1ps
`default_nettype none

// Function
// - range codes 000..100 select ranges one-five
// - new range applies only after peak value write
// - low-voltage enable permits low side below 1.8V
// - off-time code maps to decreasing product table
// - offset-cancel disable bit turns compensation off
// - slope bit selects normal or slow slopes
// - overcurrent flagged after code plus two periods
// - mode field selects fail-safe or stand-alone
// - codes 011,101,111 allow updates during fail-safe
// - per-channel enable bit switches the channel
// - sync bit selects master-slave operation
// - non-overlap field selects dead-time mode
// - low-side enable selects synchronous rectification
// - reverse-current bit holds low side to off-time end
// - bank bit selects trim channel at 0x18-0x1A
// - peak value sets threshold within active range
module dbc_regs #(
   parameter int OC_CNT_W = 3 // Overcurrent period counter width
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic wr_i, // Register write strobe
   input wire logic rd_i, // Register read strobe
   input wire logic [4:0] addr_i,
   input wire logic [9:0] wdata_i,
   output logic [9:0] rdata_o, // Read data, valid cycle after rd_i
   output logic wr_accept_o, // Write strobe taken this cycle
   input wire logic failsafe_operation_i, // Device is in fail-safe operation
   input wire logic [6:0] ch1_trim_range_i, // Trim constants channel 1
   input wire logic [7:0] ch1_trim_d12_i,
   input wire logic [7:0] ch1_trim_d34_i,
   input wire logic [6:0] ch2_trim_range_i, // Trim constants channel 2
   input wire logic [7:0] ch2_trim_d12_i,
   input wire logic [7:0] ch2_trim_d34_i,
   input wire logic [1:0] vled_low_i, // String voltage below 1.8V, per channel
   input wire logic [1:0] off_phase_i, // Channel in off-time
   input wire logic [1:0] zero_current_i, // Zero coil current detected
   input wire logic [1:0] period_end_i, // One-cycle pulse at switching period end
   input wire logic [1:0] oc_cmp_i, // Raw overcurrent comparator
   output logic [2:0] ch1_peak_range_select_o, // Active range, 0..4
   output logic [2:0] ch2_peak_range_select_o,
   output logic [12:0] ch1_peak_threshold_o, // Value scaled by range, in 0.4mA steps
   output logic [12:0] ch2_peak_threshold_o,
   output logic [12:0] ch1_off_time_product_o, // 0.01 us.V units
   output logic [12:0] ch2_off_time_product_o,
   output logic [1:0] offset_cancel_active_o,
   output logic slow_slope_o,
   output logic [1:0] overcurrent_o, // Filtered overcurrent flag
   output logic failsafe_enabled_o,
   output logic standalone_o,
   output logic load_stored_o, // Registers come from stored values
   output logic [1:0] channel_enable_o,
   output logic master_slave_sync_o,
   output logic [1:0] ch1_nonoverlap_mode_o,
   output logic [1:0] ch2_nonoverlap_mode_o,
   output logic [1:0] nonoverlap_adaptive_o,
   output logic [1:0] lowside_on_o // Low-side pre-driver gate request
);
   import dbc_pkg::*;

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [PEAK_W-1:0] ch1_peak_value_q; // Peak value fields
   logic [PEAK_W-1:0] ch2_peak_value_q;
   logic [9:0] range_cfg_q; // peak_current_range_cfg
   logic [9:0] off_time_cfg_q; // off_time_constant_cfg
   logic [9:0] mode_cfg_q; // channel_mode_control
   logic [9:0] ls_cfg_q; // low_side_driver_control
   logic [2:0] act_range1_q; // Range in force, channel 1
   logic [2:0] act_range2_q;
   logic [9:0] rdata_q;
   logic [OC_CNT_W-1:0] oc_cnt1_q; // Consecutive overcurrent periods
   logic [OC_CNT_W-1:0] oc_cnt2_q;
   logic [1:0] oc_seen_q; // Overcurrent seen in running period

   // Clamp reserved range codes to range five
   function automatic logic [2:0] range_clamp(input logic [2:0] c);
      return (c > RANGE_MAX) ? RANGE_MAX : c;
   endfunction : range_clamp

   // Advance a period counter, saturating
   function automatic logic [OC_CNT_W-1:0] oc_next(input logic [OC_CNT_W-1:0] c, input logic pend,
                                                  input logic seen);
      if (!pend) return c;
      if (!seen) return '0;
      return (&c) ? c : c + 1'b1;
   endfunction : oc_next

   // ------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------
   wire [2:0] fs_mode = mode_cfg_q[F_FSMODE +: 3];
   // Update-in-fail-safe codes all have bit 0 set with bit 1 or 2 set
   wire fs_update_ok = fs_mode[0] & (fs_mode[1] | fs_mode[2]);
   assign wr_accept_o = wr_i & (~failsafe_operation_i | fs_update_ok);
   wire we_pv1 = wr_accept_o & (addr_i == ADDR_CH1_PEAK_VALUE);
   wire we_pv2 = wr_accept_o & (addr_i == ADDR_CH2_PEAK_VALUE);
   wire we_rng = wr_accept_o & (addr_i == ADDR_PEAK_CURRENT_RANGE_CFG);
   wire we_off_time = wr_accept_o & (addr_i == ADDR_OFF_TIME_CONSTANT_CFG);
   wire we_mode = wr_accept_o & (addr_i == ADDR_CHANNEL_MODE_CONTROL);
   wire we_ls = wr_accept_o & (addr_i == ADDR_LOW_SIDE_DRIVER_CONTROL);

   // Range latches into force only on the value write, so a range
   // change never pairs with a stale value mid-update
   wire [2:0] act_range1_d = we_pv1 ? range_clamp(range_cfg_q[F_RANGE1 +: 3]) : act_range1_q;
   wire [2:0] act_range2_d = we_pv2 ? range_clamp(range_cfg_q[F_RANGE2 +: 3]) : act_range2_q;

   // Register storage
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ch1_peak_value_q <= '0;
         ch2_peak_value_q <= '0;
         range_cfg_q <= RST_REG;
         off_time_cfg_q <= RST_REG;
         mode_cfg_q <= RST_REG;
         ls_cfg_q <= RST_REG;
         act_range1_q <= '0;
         act_range2_q <= '0;
      end else begin
         if (we_pv1) ch1_peak_value_q <= wdata_i[PEAK_W-1:0];
         if (we_pv2) ch2_peak_value_q <= wdata_i[PEAK_W-1:0];
         if (we_rng) range_cfg_q <= wdata_i;
         if (we_off_time) off_time_cfg_q <= wdata_i;
         if (we_mode) mode_cfg_q <= wdata_i;
         if (we_ls) ls_cfg_q <= wdata_i;
         act_range1_q <= act_range1_d;
         act_range2_q <= act_range2_d;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   wire bank2 = ls_cfg_q[F_BANK];
   wire [6:0] trim_rng = bank2 ? ch2_trim_range_i : ch1_trim_range_i;
   wire [7:0] trim_d12 = bank2 ? ch2_trim_d12_i : ch1_trim_d12_i;
   wire [7:0] trim_d34 = bank2 ? ch2_trim_d34_i : ch1_trim_d34_i;
   logic [9:0] rd_mux;
   // Address select; unmapped reads as zero
   always_comb begin
      case (addr_i)
         ADDR_CH1_PEAK_VALUE: rd_mux = {1'b0, ch1_peak_value_q};
         ADDR_CH2_PEAK_VALUE: rd_mux = {1'b0, ch2_peak_value_q};
         ADDR_PEAK_CURRENT_RANGE_CFG: rd_mux = range_cfg_q;
         ADDR_OFF_TIME_CONSTANT_CFG: rd_mux = off_time_cfg_q;
         ADDR_CHANNEL_MODE_CONTROL: rd_mux = mode_cfg_q;
         ADDR_LOW_SIDE_DRIVER_CONTROL: rd_mux = ls_cfg_q;
         ADDR_TRIM_RANGE: rd_mux = {3'h0, trim_rng};
         ADDR_TRIM_D12: rd_mux = {2'h0, trim_d12};
         ADDR_TRIM_D34: rd_mux = {2'h0, trim_d34};
         default: rd_mux = 10'h000;
      endcase
   end

   // Read data holds until the next read
   always_ff @(posedge clk_i) begin
      if (!nrst_i) rdata_q <= 10'h000;
      else if (rd_i) rdata_q <= rd_mux;
   end
   assign rdata_o = rdata_q;

   // ------------------------------------------------------------
   // Overcurrent filter
   // ------------------------------------------------------------
   wire [1:0] oc_filt = mode_cfg_q[F_OCFILT +: 2];
   wire [OC_CNT_W-1:0] oc_limit = OC_CNT_W'(oc_filt) + OC_CNT_W'(1);
   wire [OC_CNT_W-1:0] oc_cnt1_d = oc_next(oc_cnt1_q, period_end_i[0], oc_seen_q[0] | oc_cmp_i[0]);
   wire [OC_CNT_W-1:0] oc_cnt2_d = oc_next(oc_cnt2_q, period_end_i[1], oc_seen_q[1] | oc_cmp_i[1]);
   // Seen latch restarts each period, so one clean period breaks the run
   wire [1:0] oc_seen_d = (oc_seen_q | oc_cmp_i) & ~period_end_i;

   // Period counters
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         oc_cnt1_q <= '0;
         oc_cnt2_q <= '0;
         oc_seen_q <= 2'h0;
      end else begin
         oc_cnt1_q <= oc_cnt1_d;
         oc_cnt2_q <= oc_cnt2_d;
         oc_seen_q <= oc_seen_d;
      end
   end
   // Flag once the run is longer than code plus one periods
   assign overcurrent_o = {oc_cnt2_q > oc_limit, oc_cnt1_q > oc_limit};

   // ------------------------------------------------------------
   // Field decode to the power stage
   // ------------------------------------------------------------
   assign ch1_peak_range_select_o = act_range1_q;
   assign ch2_peak_range_select_o = act_range2_q;
   // Step doubles per range: 0.4mA base times 2^range
   assign ch1_peak_threshold_o = 13'(ch1_peak_value_q) << act_range1_q;
   assign ch2_peak_threshold_o = 13'(ch2_peak_value_q) << act_range2_q;
   assign ch1_off_time_product_o = dbc_off_time_lut(off_time_cfg_q[F_TOFF1 +: 5]);
   assign ch2_off_time_product_o = dbc_off_time_lut(off_time_cfg_q[F_TOFF2 +: 5]);
   assign offset_cancel_active_o = ~{mode_cfg_q[F_OCD2], mode_cfg_q[F_OCD1]};
   assign slow_slope_o = mode_cfg_q[F_SLOPE];
   assign failsafe_enabled_o = (fs_mode >= 3'h2) & (fs_mode <= 3'h5);
   assign standalone_o = fs_mode[2] & fs_mode[1];
   assign load_stored_o = (fs_mode == 3'h1) | (fs_mode >= 3'h4);
   assign channel_enable_o = {mode_cfg_q[F_EN2], mode_cfg_q[F_EN1]};
   assign master_slave_sync_o = ls_cfg_q[F_SYNC];
   assign ch1_nonoverlap_mode_o = ls_cfg_q[F_NO1 +: 2];
   assign ch2_nonoverlap_mode_o = ls_cfg_q[F_NO2 +: 2];
   // Codes 00 and 01 are adaptive, 10 and 11 fixed
   assign nonoverlap_adaptive_o = {~ls_cfg_q[F_NO2 + 1], ~ls_cfg_q[F_NO1 + 1]};

   // Low-side gate: enabled, off-time, low-voltage permit, reverse current
   wire [1:0] ls_en = {ls_cfg_q[F_LSEN2], ls_cfg_q[F_LSEN1]};
   wire [1:0] lv_ok = ~vled_low_i | {range_cfg_q[F_LV_EN2], range_cfg_q[F_LV_EN1]};
   wire [1:0] rev_ok = {ls_cfg_q[F_REV2], ls_cfg_q[F_REV1]} | ~zero_current_i;
   assign lowside_on_o = channel_enable_o & ls_en & lv_ok & rev_ok & off_phase_i;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_range_hold;
      @(posedge clk_i) disable iff (!nrst_i) !we_pv1 |=> $stable(ch1_peak_range_select_o);
   endproperty
   a_range_hold: assert property (p_range_hold) else $error("range changed without value write");

   property p_range_take;
      @(posedge clk_i) disable iff (!nrst_i)
         we_pv1 && range_cfg_q[F_RANGE1 +: 3] <= RANGE_MAX |=> ch1_peak_range_select_o == $past(range_cfg_q[5:3]);
   endproperty
   a_range_take: assert property (p_range_take) else $error("range not applied on value write");

   property p_fs_block;
      @(posedge clk_i) disable iff (!nrst_i)
         wr_i && failsafe_operation_i && !(fs_mode inside {3'h3, 3'h5, 3'h7}) |-> !wr_accept_o;
   endproperty
   a_fs_block: assert property (p_fs_block) else $error("write accepted in fail-safe");

   property p_fs_allow;
      @(posedge clk_i) disable iff (!nrst_i) wr_i && (fs_mode inside {3'h3, 3'h5, 3'h7}) |-> wr_accept_o;
   endproperty
   a_fs_allow: assert property (p_fs_allow) else $error("update refused in update mode");

   property p_oc_clear;
      @(posedge clk_i) disable iff (!nrst_i)
         period_end_i[0] && !oc_seen_q[0] && !oc_cmp_i[0] |=> oc_cnt1_q == '0 ##0 !overcurrent_o[0];
   endproperty
   a_oc_clear: assert property (p_oc_clear) else $error("counter kept after clean period");

   property p_oc_min;
      @(posedge clk_i) disable iff (!nrst_i) overcurrent_o[0] |-> oc_cnt1_q >= 3'(oc_filt) + 3'h2;
   endproperty
   a_oc_min: assert property (p_oc_min) else $error("overcurrent flagged too early");

   property p_off_time_ends;
      @(posedge clk_i) disable iff (!nrst_i)
         off_time_cfg_q[F_TOFF1 +: 5] == 5'h1F |-> ch1_off_time_product_o == 13'd500;
   endproperty
   a_off_time_ends: assert property (p_off_time_ends) else $error("off-time product wrong at top code");

   property p_lv_block;
      @(posedge clk_i) disable iff (!nrst_i) vled_low_i[0] && !range_cfg_q[F_LV_EN1] |-> !lowside_on_o[0];
   endproperty
   a_lv_block: assert property (p_lv_block) else $error("low side on at low voltage");

   property p_rev;
      @(posedge clk_i) disable iff (!nrst_i) zero_current_i[1] && !ls_cfg_q[F_REV2] |-> !lowside_on_o[1];
   endproperty
   a_rev: assert property (p_rev) else $error("low side kept on at zero current");

   property p_async;
      @(posedge clk_i) disable iff (!nrst_i) !ls_cfg_q[F_LSEN1] |-> !lowside_on_o[0];
   endproperty
   a_async: assert property (p_async) else $error("low side active in asynchronous mode");

   property p_bank;
      @(posedge clk_i) disable iff (!nrst_i)
         rd_i && addr_i == ADDR_TRIM_RANGE |=> rdata_o == {3'h0, $past(trim_rng)};
   endproperty
   a_bank: assert property (p_bank) else $error("trim read wrong");

   property p_range_hold2;
      @(posedge clk_i) disable iff (!nrst_i) !we_pv2 |=> $stable(ch2_peak_range_select_o);
   endproperty
   a_range_hold2: assert property (p_range_hold2) else $error("ch2 range moved without value write");

   property p_oc_rise;
      @(posedge clk_i) disable iff (!nrst_i)
         period_end_i[0] && (oc_seen_q[0] || oc_cmp_i[0]) && oc_cnt1_q == oc_limit |=> overcurrent_o[0];
   endproperty
   a_oc_rise: assert property (p_oc_rise) else $error("overcurrent not flagged after filter span");

   property p_refused;
      @(posedge clk_i) disable iff (!nrst_i) wr_i && !wr_accept_o |=> $stable(off_time_cfg_q) && $stable(mode_cfg_q);
   endproperty
   a_refused: assert property (p_refused) else $error("refused write changed a register");

   property p_ch_off;
      @(posedge clk_i) disable iff (!nrst_i) !mode_cfg_q[F_EN1] |-> !lowside_on_o[0];
   endproperty
   a_ch_off: assert property (p_ch_off) else $error("low side on in disabled channel");
endmodule : dbc_regs

`default_nettype wire

// file: rtl/dbc_pkg.sv
// Package: addresses, field layout, reset values and decode helpers of the buck control bank
package dbc_pkg;
   // ------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------
   localparam logic [4:0] ADDR_CH1_PEAK_VALUE = 5'h01; // Channel 1 peak value
   localparam logic [4:0] ADDR_CH2_PEAK_VALUE = 5'h02; // Channel 2 peak value
   localparam logic [4:0] ADDR_PEAK_CURRENT_RANGE_CFG = 5'h03;
   localparam logic [4:0] ADDR_OFF_TIME_CONSTANT_CFG = 5'h04;
   localparam logic [4:0] ADDR_CHANNEL_MODE_CONTROL = 5'h05;
   localparam logic [4:0] ADDR_LOW_SIDE_DRIVER_CONTROL = 5'h06;
   localparam logic [4:0] ADDR_TRIM_RANGE = 5'h18; // Banked trim window start
   localparam logic [4:0] ADDR_TRIM_D12 = 5'h19;
   localparam logic [4:0] ADDR_TRIM_D34 = 5'h1A; // Banked trim window end
   // ------------------------------------------------------------
   // Widths and reset values
   // ------------------------------------------------------------
   localparam int REG_W = 10; // Every register is 10 bits
   localparam int PEAK_W = 9; // Peak value field
   localparam logic [9:0] RST_REG = 10'h000; // All control registers clear
   localparam logic [2:0] RANGE_MAX = 3'h4; // Code of range five
   // ------------------------------------------------------------
   // Field positions (lsb of each field)
   // ------------------------------------------------------------
   localparam int F_LV_EN1 = 7; // Range reg: ch1 low-voltage enable
   localparam int F_LV_EN2 = 6;
   localparam int F_RANGE1 = 3; // Range reg: 3-bit fields
   localparam int F_RANGE2 = 0;
   localparam int F_TOFF1 = 5; // Off-time reg: 5-bit fields
   localparam int F_TOFF2 = 0;
   localparam int F_OCD1 = 9; // Mode reg
   localparam int F_OCD2 = 8;
   localparam int F_SLOPE = 7;
   localparam int F_OCFILT = 5; // 2 bits
   localparam int F_FSMODE = 2; // 3 bits
   localparam int F_EN1 = 1;
   localparam int F_EN2 = 0;
   localparam int F_SYNC = 9; // Low-side reg
   localparam int F_NO1 = 7; // 2 bits
   localparam int F_NO2 = 5; // 2 bits
   localparam int F_LSEN1 = 4;
   localparam int F_LSEN2 = 3;
   localparam int F_REV1 = 2;
   localparam int F_REV2 = 1;
   localparam int F_BANK = 0;
   // ------------------------------------------------------------
   // Off-time product table, unit 0.01 us.V
   // ------------------------------------------------------------
   function automatic logic [12:0] dbc_off_time_lut(input logic [4:0] code);
      logic [12:0] t [0:31];
      t = '{13'd5000, 13'd4640, 13'd4310, 13'd4000, 13'd3710, 13'd3450, 13'd3200, 13'd2970,
            13'd2760, 13'd2560, 13'd2380, 13'd2210, 13'd2050, 13'd1900, 13'd1770, 13'd1640,
            13'd1520, 13'd1410, 13'd1310, 13'd1220, 13'd1130, 13'd1050, 13'd975, 13'd905,
            13'd841, 13'd780, 13'd725, 13'd673, 13'd625, 13'd580, 13'd538, 13'd500};
      return t[code];
   endfunction : dbc_off_time_lut
endpackage : dbc_pkg

// file: sim/dbc_stage_model.sv
// Power-stage stand-in: period pulses, comparator, sense levels, trim constants
`timescale 1ns/1ps
`default_nettype none
module dbc_stage_model #(
   parameter int PERIOD = 4, // Cycles per switching period, short for simulation
   parameter logic [22:0] TRIM1 = 23'h000000, // Trim set, channel 1
   parameter logic [22:0] TRIM2 = 23'h000000 // Trim set, channel 2
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic oc_i, // Overcurrent on both channels
   input wire logic [2:0] cond_i, // {zero current, off phase, low string voltage}
   output logic [1:0] period_end_o,
   output logic [1:0] oc_cmp_o,
   output logic [1:0] vled_low_o,
   output logic [1:0] off_phase_o,
   output logic [1:0] zero_current_o,
   output logic [22:0] trim1_o,
   output logic [22:0] trim2_o
);
   // ------------------------------------------------------------
   // Switching period timer
   // ------------------------------------------------------------
   logic [7:0] cnt_q; // Position in period
   logic [7:0] cnt_d;
   // Free-running, so a slow bench never stretches a period
   assign cnt_d = (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   // Limitation: both channels share one period and one set of conditions
   assign period_end_o = {2{cnt_q == 8'(PERIOD - 1)}};
   assign oc_cmp_o = {2{oc_i}};
   assign vled_low_o = {2{cond_i[0]}};
   assign off_phase_o = {2{cond_i[1]}};
   assign zero_current_o = {2{cond_i[2]}};
   assign trim1_o = TRIM1;
   assign trim2_o = TRIM2;
endmodule : dbc_stage_model
`default_nettype wire

// file: sim/dual_buck_control_regs_tb.sv
// Self-checking bench for the buck control register bank
`timescale 1ns/1ps
`default_nettype none
module dual_buck_control_regs_tb;
   import dbc_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam logic [22:0] TRIM1 = 23'h2A5CA3; // Arbitrary value
   localparam logic [22:0] TRIM2 = 23'h15C639; // Arbitrary value
   logic clk, nrst, wr, rd, fs, oc, last_acc;
   logic [4:0] addr;
   logic [9:0] wdata, rdata;
   logic [2:0] cond, rs1, rs2;
   logic [1:0] pe, occ, vlow, offp, zc, oca, ovc, chen, no1, no2, noa, lso;
   logic [22:0] tr1, tr2;
   logic [12:0] th1, th2, tp1, tp2;
   logic acc_w, slow, fse, sal, lds, sync;
   int fails, cmp_count;
   dbc_stage_model #(.PERIOD(4), .TRIM1(TRIM1), .TRIM2(TRIM2)) i_stage (.clk_i(clk), .nrst_i(nrst), .oc_i(oc),
      .cond_i(cond), .period_end_o(pe), .oc_cmp_o(occ), .vled_low_o(vlow), .off_phase_o(offp),
      .zero_current_o(zc), .trim1_o(tr1), .trim2_o(tr2));
   dbc_regs #(.OC_CNT_W(3)) i_dut (.clk_i(clk), .nrst_i(nrst), .wr_i(wr), .rd_i(rd), .addr_i(addr),
      .wdata_i(wdata), .rdata_o(rdata), .wr_accept_o(acc_w), .failsafe_operation_i(fs),
      .ch1_trim_range_i(tr1[22:16]), .ch1_trim_d12_i(tr1[15:8]), .ch1_trim_d34_i(tr1[7:0]),
      .ch2_trim_range_i(tr2[22:16]), .ch2_trim_d12_i(tr2[15:8]), .ch2_trim_d34_i(tr2[7:0]),
      .vled_low_i(vlow), .off_phase_i(offp), .zero_current_i(zc), .period_end_i(pe), .oc_cmp_i(occ),
      .ch1_peak_range_select_o(rs1), .ch2_peak_range_select_o(rs2), .ch1_peak_threshold_o(th1),
      .ch2_peak_threshold_o(th2), .ch1_off_time_product_o(tp1), .ch2_off_time_product_o(tp2),
      .offset_cancel_active_o(oca), .slow_slope_o(slow), .overcurrent_o(ovc), .failsafe_enabled_o(fse),
      .standalone_o(sal), .load_stored_o(lds), .channel_enable_o(chen), .master_slave_sync_o(sync),
      .ch1_nonoverlap_mode_o(no1), .ch2_nonoverlap_mode_o(no2), .nonoverlap_adaptive_o(noa),
      .lowside_on_o(lso));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Bus cycles and comparison
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Write strobe held one cycle; acceptance sampled while it stands
   task automatic wrreg(input logic [4:0] a, input logic [9:0] d);
      @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
      #1 last_acc = acc_w;
      @(posedge clk) wr <= 1'b0;
      #1;
   endtask : wrreg
   task automatic rdchk(input logic [4:0] a, input logic [9:0] exp);
      @(posedge clk) begin rd <= 1'b1; addr <= a; end
      @(posedge clk) rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rdchk
   // Period end is read at the edge itself, before the timer moves on
   task automatic wait_pulse;
      int n;
      n = 0;
      do begin @(posedge clk); n++; end while (pe[0] !== 1'b1 && n < 16);
      #1;
   endtask : wait_pulse
   task automatic summarize;
      $display("comparisons=%0d mismatches=%0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rdchk(ADDR_PEAK_CURRENT_RANGE_CFG, RST_REG);
      rdchk(ADDR_OFF_TIME_CONSTANT_CFG, RST_REG);
      rdchk(ADDR_CHANNEL_MODE_CONTROL, RST_REG);
      rdchk(ADDR_LOW_SIDE_DRIVER_CONTROL, RST_REG);
      chk(tp1, 13'h1388);
      chk(oca, 2'h3);
      $display("test reset done");
   endtask : t_reset
   // Range codes only take hold on the peak value write; 5..7 clamp
   task automatic t_range;
      logic [2:0] p1, p2, e1, e2;
      p1 = 3'h0;
      p2 = 3'h0;
      for (int k = 0; k < 8; k++) begin
         e1 = (k > 4) ? RANGE_MAX : 3'(k);
         e2 = (k < 3) ? RANGE_MAX : 3'(7 - k);
         wrreg(ADDR_PEAK_CURRENT_RANGE_CFG, {4'h0, 3'(k), 3'(7 - k)});
         chk(rs1, p1);
         rdchk(ADDR_PEAK_CURRENT_RANGE_CFG, {4'h0, 3'(k), 3'(7 - k)});
         wrreg(ADDR_CH1_PEAK_VALUE, 10'h3FF);
         chk(rs1, e1);
         chk(rs2, p2);
         chk(th1, 16'h01FF << e1);
         wrreg(ADDR_CH2_PEAK_VALUE, 10'h0A5);
         chk(th2, 16'h00A5 << e2);
         p1 = e1;
         p2 = e2;
      end
      rdchk(ADDR_CH1_PEAK_VALUE, 10'h1FF);
      rdchk(5'h10, 10'h000);
      $display("test range done");
   endtask : t_range
   task automatic t_off_time;
      logic [4:0] tc [4] = '{5'h00, 5'h03, 5'h16, 5'h1F};
      logic [12:0] tv [4] = '{13'h1388, 13'h0FA0, 13'h03CF, 13'h01F4};
      for (int i = 0; i < 4; i++) begin
         wrreg(ADDR_OFF_TIME_CONSTANT_CFG, {tc[i], tc[3 - i]});
         chk(tp1, tv[i]);
         chk(tp2, tv[3 - i]);
      end
      $display("test off-time done");
   endtask : t_off_time
   // Every mode code, then a write attempted during fail-safe operation
   task automatic t_mode;
      logic [9:0] w, t, cur;
      logic [2:0] m;
      cur = 10'h000;
      wrreg(ADDR_OFF_TIME_CONSTANT_CFG, cur);
      for (int i = 0; i < 8; i++) begin
         m = 3'(i);
         w = {m[0], m[1], m[2], 2'h0, m, m[1], m[0]};
         wrreg(ADDR_CHANNEL_MODE_CONTROL, w);
         chk(oca, {~w[8], ~w[9]});
         chk(slow, w[7]);
         chk({fse, sal, lds}, {m >= 3'h2 && m <= 3'h5, m >= 3'h6, m == 3'h1 || m >= 3'h4});
         chk(chen, {w[0], w[1]});
         rdchk(ADDR_CHANNEL_MODE_CONTROL, w);
         @(posedge clk) fs <= 1'b1;
         t = {m, ~m, 4'h5};
         wrreg(ADDR_OFF_TIME_CONSTANT_CFG, t);
         chk(last_acc, m[0] && m != 3'h1);
         if (m[0] && m != 3'h1) cur = t;
         @(posedge clk) fs <= 1'b0;
         rdchk(ADDR_OFF_TIME_CONSTANT_CFG, cur);
      end
      $display("test mode done");
   endtask : t_mode
   // All combinations of low-side, low-voltage and reverse-current bits and stage conditions
   task automatic t_lowside;
      logic [5:0] b;
      logic e;
      wrreg(ADDR_CHANNEL_MODE_CONTROL, 10'h003);
      for (int i = 0; i < 64; i++) begin
         b = 6'(i);
         @(posedge clk) cond <= b[5:3];
         wrreg(ADDR_PEAK_CURRENT_RANGE_CFG, {2'h0, b[2], b[2], 6'h00});
         wrreg(ADDR_LOW_SIDE_DRIVER_CONTROL, {5'h00, b[0], b[0], b[1], b[1], 1'b0});
         e = b[0] & b[4] & (~b[3] | b[2]) & (b[1] | ~b[5]);
         chk(lso, {e, e});
      end
      wrreg(ADDR_CHANNEL_MODE_CONTROL, 10'h001);
      chk(lso, 2'h2);
      $display("test low side done");
   endtask : t_lowside
   task automatic t_banks;
      logic [9:0] w;
      logic [1:0] j;
      logic [22:0] tr;
      for (int i = 0; i < 4; i++) begin
         j = 2'(i);
         w = {j[0], j, ~j, 4'h0, j[1]};
         tr = j[1] ? TRIM2 : TRIM1;
         wrreg(ADDR_LOW_SIDE_DRIVER_CONTROL, w);
         chk({sync, no1, no2, noa}, {j[0], j, ~j, j[1], ~j[1]});
         rdchk(ADDR_LOW_SIDE_DRIVER_CONTROL, w);
         rdchk(ADDR_TRIM_RANGE, {3'h0, tr[22:16]});
         rdchk(ADDR_TRIM_D12, {2'h0, tr[15:8]});
         rdchk(ADDR_TRIM_D34, {2'h0, tr[7:0]});
      end
      $display("test banks done");
   endtask : t_banks
   // Flag after filter code plus two dirty periods, cleared by a clean one
   task automatic t_overcurrent;
      for (int c = 0; c < 4; c++) begin
         wrreg(ADDR_CHANNEL_MODE_CONTROL, {3'h0, 2'(c), 5'h03});
         wait_pulse();
         wait_pulse();
         @(posedge clk) oc <= 1'b1;
         for (int n = 1; n <= c + 2; n++) begin
            wait_pulse();
            chk(ovc, (n == c + 2) ? 2'h3 : 2'h0);
         end
         @(posedge clk) oc <= 1'b0;
         wait_pulse();
         chk(ovc, 2'h3);
         wait_pulse();
         chk(ovc, 2'h0);
      end
      $display("test overcurrent done");
   endtask : t_overcurrent
   initial begin
      fails = 0;
      cmp_count = 0;
      {nrst, wr, rd, fs, oc, last_acc} = 6'h00;
      addr = 5'h00;
      wdata = 10'h000;
      cond = 3'h0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_range();
      t_off_time();
      t_mode();
      t_lowside();
      t_banks();
      t_overcurrent();
      summarize();
   end
   // Watchdog well beyond the under one thousand cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      $display("watchdog expired");
      summarize();
   end
endmodule : dual_buck_control_regs_tb
`default_nettype wire
